// ===== inc/dsacc_defines.svh
// Constants for the data space byte/word access unit.
// Assumes inclusion by bare name from the design files.
// What this block does
// - Separate read and write address generators
// - Byte addresses; low half is local memory
// - Upper half routes to extended data window
// - General RAM decoded from 0800h to 7FFFh
// - Low byte even address, high byte odd
// - Post-increment by one byte or two word
// - Byte read picks lane, returns on low lane
// - Shared word decode, separate lane write strobes
// - Odd word access raises address error
// - Read completes; write suppressed; then trap
// - Byte load writes only register low byte
// - Sign-extend op copies bit 7 upward
// - Upper-byte-clear op zeroes register high byte
// - First 2 Kbytes hold control registers
// - Unimplemented control addresses read zero when no write shares the cycle
`ifndef DSACC_DEFINES_SVH
`define DSACC_DEFINES_SVH
`define DSACC_WINDOW_BASE 16'h8000
`define DSACC_RAM_BASE    16'h0800
`define DSACC_RAM_LAST    16'h7FFF
`define DSACC_CTRL_LAST   16'h07FF
`define DSACC_RAM_WORDS   15360
`define DSACC_STEP_BYTE   16'h0001
`define DSACC_STEP_WORD   16'h0002
`define DSACC_REG_RESET   16'h0000
`endif

// ===== inc/dsacc_pkg.sv
// Types shared by the access unit and its address generator.
// Assumes the defines header sits on the include path.
package dsacc_pkg;
    // Where a decoded address lands
    typedef enum logic [1:0] {
        DSACC_REGION_CTRL,
        DSACC_REGION_RAM,
        DSACC_REGION_WINDOW
    } dsacc_region_t;

    // One memory request from the core
    typedef struct packed {
        logic        valid;      // Request present
        logic        is_byte;    // Byte sized when set
        logic        post_inc;   // Advance pointer after use
        logic [15:0] pointer;    // Effective address source
    } dsacc_req_t;

    // Register-side operation on a working register value
    typedef enum logic [1:0] {
        DSACC_EXT_NONE,
        DSACC_EXT_BYTE_LOAD,
        DSACC_EXT_SIGN,
        DSACC_EXT_CLEAR
    } dsacc_ext_t;
endpackage : dsacc_pkg

// ===== logic/dsacc_agu.sv
// One address generation unit: effective address and post-increment.
// Assumes requests are synchronous to ref_clk.
`timescale 1ns/100ps
`include "dsacc_defines.svh"
module dsacc_agu
    import dsacc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire dsacc_req_t req,
    output logic [15:0]     effective_address,
    output logic [15:0]     next_pointer,
    output logic            misaligned
);
    // Address is the pointer itself, byte granular
    assign effective_address = req.pointer;
    // Word access must be even
    assign misaligned = req.valid && !req.is_byte && req.pointer[0];
    // Post increment by size
    always_comb begin
        if (req.post_inc) begin
            next_pointer = req.pointer + (req.is_byte ? `DSACC_STEP_BYTE
                                                      : `DSACC_STEP_WORD);
        end else begin
            next_pointer = req.pointer;
        end
    end

    // Increment step matches operand size
    step_size_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        req.post_inc |-> next_pointer - req.pointer == (req.is_byte ? 16'h0001 : 16'h0002))
        else $error("pointer step wrong");
endmodule : dsacc_agu

// ===== logic/dsacc_top.sv
// Data space access unit: two address generators, lanes, faults.
// Assumes the core holds a request stable for one cycle and
// supplies control-register read data for that region.
`timescale 1ns/100ps
`include "dsacc_defines.svh"
module dsacc_top
    import dsacc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire dsacc_req_t  rd_req,
    input  wire dsacc_req_t  wr_req,
    input  wire logic [15:0] wr_data,
    output logic [15:0]      rd_pointer_next,
    output logic [15:0]      wr_pointer_next,
    output logic [15:0]      rd_data,
    output logic             rd_valid,
    input  wire logic [15:0] ctrl_rd_data,
    input  wire logic        ctrl_rd_hit,
    output logic             ctrl_wr_en,
    output logic [1:0]       ctrl_wr_lane,
    output logic [15:0]      ctrl_addr,
    output logic             window_rd,
    output logic             window_wr,
    output logic [1:0]       window_wr_lane,
    output logic [15:0]      window_addr,
    input  wire logic [15:0] window_rd_data,
    output logic             fault_pulse,
    output logic             fault_on_write,
    input  wire logic [15:0] reg_in,
    input  wire logic [7:0]  byte_in,
    input  wire dsacc_ext_t  ext_op,
    output logic [15:0]      reg_out
);
    // Region decode used by both generators
    function automatic dsacc_region_t region_of(input logic [15:0] a);
        if (a >= `DSACC_WINDOW_BASE)
            return DSACC_REGION_WINDOW;
        else if (a >= `DSACC_RAM_BASE)
            return DSACC_REGION_RAM;
        else
            return DSACC_REGION_CTRL;
    endfunction : region_of

    // Lane strobes for a write of given size
    function automatic logic [1:0] lanes_of(input logic is_byte, input logic a0);
        if (!is_byte)
            return 2'h3;
        else
            return a0 ? 2'h2 : 2'h1;
    endfunction : lanes_of

    logic [15:0]   rd_ea;      // Read effective address
    logic [15:0]   wr_ea;      // Write effective address
    logic          rd_mis;     // Read misaligned
    logic          wr_mis;     // Write misaligned
    dsacc_region_t rd_region;  // Read target
    dsacc_region_t wr_region;  // Write target
    logic [1:0]    wr_lanes;   // Per-lane strobes
    logic          wr_go;      // Write allowed
    logic [7:0]    lane0 [0:`DSACC_RAM_WORDS-1];  // Even byte lane
    logic [7:0]    lane1 [0:`DSACC_RAM_WORDS-1];  // Odd byte lane
    logic [13:0]   rd_idx;     // Read RAM word index
    logic [13:0]   wr_idx;     // Write RAM word index
    logic [15:0]   ram_word;   // Registered RAM word
    logic          rd_byte_q;  // Byte read in flight
    logic          rd_a0_q;    // Lane select in flight
    dsacc_region_t rd_region_q;// Region in flight

    // Read generator, used only for reads
    dsacc_agu u_rd_agu (
        .ref_clk           (ref_clk),
        .nrst              (nrst),
        .req               (rd_req),
        .effective_address (rd_ea),
        .next_pointer      (rd_pointer_next),
        .misaligned        (rd_mis)
    );

    // Write generator, for writes and for the control and window read address when a write shares the cycle
    dsacc_agu u_wr_agu (
        .ref_clk           (ref_clk),
        .nrst              (nrst),
        .req               (wr_req),
        .effective_address (wr_ea),
        .next_pointer      (wr_pointer_next),
        .misaligned        (wr_mis)
    );

    assign rd_region = region_of(rd_ea);
    assign wr_region = region_of(wr_ea);
    assign wr_lanes  = lanes_of(wr_req.is_byte, wr_ea[0]);
    assign wr_go     = wr_req.valid && !wr_mis;
    assign rd_idx    = 14'(rd_ea[14:1] - (`DSACC_RAM_BASE >> 1));
    assign wr_idx    = 14'(wr_ea[14:1] - (`DSACC_RAM_BASE >> 1));

    // Control and window strobes, write suppressed on fault
    assign ctrl_addr      = wr_req.valid ? wr_ea : rd_ea;
    assign ctrl_wr_en     = wr_go && wr_region == DSACC_REGION_CTRL;
    assign ctrl_wr_lane   = wr_lanes;
    assign window_addr    = wr_req.valid ? wr_ea : rd_ea;
    assign window_wr      = wr_go && wr_region == DSACC_REGION_WINDOW;
    assign window_wr_lane = wr_lanes;
    assign window_rd      = rd_req.valid && rd_region == DSACC_REGION_WINDOW;

    // RAM lane writes, each lane its own strobe
    always_ff @(posedge ref_clk) begin
        if (wr_go && wr_region == DSACC_REGION_RAM) begin
            if (wr_lanes[0]) begin
                lane0[wr_idx] <= wr_data[7:0];
            end
            if (wr_lanes[1]) begin
                lane1[wr_idx] <= wr_lanes[0] ? wr_data[15:8] : wr_data[7:0];
            end
        end
    end

    // Whole word read regardless of size
    always_ff @(posedge ref_clk) begin
        ram_word <= {lane1[rd_idx], lane0[rd_idx]};
    end

    // Read context tracking
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_valid    <= 1'b0;
            rd_byte_q   <= 1'b0;
            rd_a0_q     <= 1'b0;
            rd_region_q <= DSACC_REGION_CTRL;
        end else begin
            rd_valid    <= rd_req.valid;
            rd_byte_q   <= rd_req.is_byte;
            rd_a0_q     <= rd_ea[0];
            rd_region_q <= rd_region;
        end
    end

    // Control region source, zero where nothing answers
    logic [15:0] ctrl_word;       // Registered control read
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_word <= `DSACC_REG_RESET;
        end else if (ctrl_rd_hit) begin
            ctrl_word <= ctrl_rd_data;
        end else begin
            ctrl_word <= 16'h0000;
        end
    end

    // Window source captured
    logic [15:0] win_word;        // Registered window read
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            win_word <= `DSACC_REG_RESET;
        end else begin
            win_word <= window_rd_data;
        end
    end

    // Lane selection onto the low byte
    logic [15:0] src_word;        // Word from chosen region
    always_comb begin
        unique case (rd_region_q)
            DSACC_REGION_CTRL:   src_word = ctrl_word;
            DSACC_REGION_RAM:    src_word = ram_word;
            DSACC_REGION_WINDOW: src_word = win_word;
            default:             src_word = 16'h0000;
        endcase
        if (rd_byte_q) begin
            rd_data = {8'h00, rd_a0_q ? src_word[15:8] : src_word[7:0]};
        end else begin
            rd_data = src_word;
        end
    end

    // Fault request, one cycle, write has priority in direction
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fault_pulse    <= 1'b0;
            fault_on_write <= 1'b0;
        end else begin
            fault_pulse    <= rd_mis || wr_mis;
            fault_on_write <= wr_mis;
        end
    end

    // Working register byte load and extension ops
    always_comb begin
        unique case (ext_op)
            DSACC_EXT_NONE:      reg_out = reg_in;
            DSACC_EXT_BYTE_LOAD: reg_out = {reg_in[15:8], byte_in};
            DSACC_EXT_SIGN:      reg_out = {{8{reg_in[7]}}, reg_in[7:0]};
            DSACC_EXT_CLEAR:     reg_out = {8'h00, reg_in[7:0]};
        endcase
    end

    // Fault follows an odd word read one cycle later
    odd_word_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        (rd_req.valid && !rd_req.is_byte && rd_req.pointer[0]) |=> fault_pulse)
        else $error("missing fault on odd read");

    // Faulting write raises neither the control nor the window write strobe
    write_block_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        wr_mis |-> !ctrl_wr_en && !window_wr)
        else $error("faulting write not suppressed");

    // Fault lasts one cycle without a new cause
    fault_single_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        fault_pulse && !$past(rd_mis) && !$past(wr_mis) |-> 1'b0)
        else $error("fault without cause");

    // Direction flag tracks write faults
    fault_dir_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        wr_mis |=> fault_pulse && fault_on_write)
        else $error("fault direction wrong");

    // Byte lanes strobe by address bit
    byte_lane_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        wr_req.valid && wr_req.is_byte |-> ctrl_wr_lane == (wr_ea[0] ? 2'h2 : 2'h1))
        else $error("byte lane wrong");

    // Byte reads clear the upper lane
    byte_read_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        rd_req.valid && rd_req.is_byte |=> rd_data[15:8] == 8'h00)
        else $error("byte read high lane");

    // Upper half goes to the window
    window_route_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        rd_req.valid && rd_ea[15] |-> window_rd)
        else $error("window not selected");

    // Sign extension copies bit seven
    sign_ext_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        ext_op == DSACC_EXT_SIGN |-> reg_out[15:8] == {8{reg_in[7]}})
        else $error("sign extend wrong");

    // Byte load keeps the high byte
    byte_load_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        ext_op == DSACC_EXT_BYTE_LOAD |-> reg_out[15:8] == reg_in[15:8])
        else $error("byte load touched high");

    // Unanswered control reads return zero
    ctrl_zero_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        rd_req.valid && !wr_req.valid && rd_region == DSACC_REGION_CTRL && !ctrl_rd_hit
        |=> rd_data == 16'h0000)
        else $error("unimplemented read not zero");
endmodule : dsacc_top

// ===== verif/dsacc_core_model.sv
// Core-side partner: control-register read source and window data source.
// Assumes it sees the access unit's address outputs directly.
`timescale 1ns/100ps
module dsacc_core_model (
    input  wire logic [15:0] ctrl_addr,
    input  wire logic [15:0] window_addr,
    output logic [15:0]      ctrl_rd_data,
    output logic             ctrl_rd_hit,
    output logic [15:0]      window_rd_data
);
    // Only the lowest 256 bytes hold implemented registers
    assign ctrl_rd_hit    = (ctrl_addr < 16'h0100);
    // Unimplemented places carry a non-zero pattern, so zeroing is visible
    assign ctrl_rd_data   = ctrl_rd_hit ? {8'hC3, ctrl_addr[7:0]} : ~ctrl_addr;
    // Window data is the inverted address
    assign window_rd_data = ~window_addr;
endmodule : dsacc_core_model

// ===== verif/dsacc_top_tb_top.sv
// Self-checking bench for the data space access unit.
// Assumes the core model answers control and window reads.
`timescale 1ns/100ps
module dsacc_top_tb_top
    import dsacc_pkg::*;
;
    logic        ref_clk;                       // 20 MHz clock
    logic        nrst;                          // Active-low reset
    dsacc_req_t  rd_req;                        // Read request
    dsacc_req_t  wr_req;                        // Write request
    logic [15:0] wr_data;                       // Write data
    logic [15:0] reg_in;                        // Register operand
    logic [7:0]  byte_in;                       // Loaded byte
    dsacc_ext_t  ext_op;                        // Register operation
    logic [15:0] rd_pointer_next, wr_pointer_next, rd_data, ctrl_addr;
    logic [15:0] window_addr, reg_out, ctrl_rd_data, window_rd_data;
    logic        rd_valid, ctrl_wr_en, window_rd, window_wr, fault_pulse;
    logic        fault_on_write, ctrl_rd_hit;
    logic [1:0]  ctrl_wr_lane, window_wr_lane;
    int          n_mismatch;                    // Failed compares
    int          checked;                       // All compares

    dsacc_top u_dsacc_top (.ref_clk(ref_clk), .nrst(nrst), .rd_req(rd_req),
        .wr_req(wr_req), .wr_data(wr_data), .rd_pointer_next(rd_pointer_next),
        .wr_pointer_next(wr_pointer_next), .rd_data(rd_data), .rd_valid(rd_valid),
        .ctrl_rd_data(ctrl_rd_data), .ctrl_rd_hit(ctrl_rd_hit),
        .ctrl_wr_en(ctrl_wr_en), .ctrl_wr_lane(ctrl_wr_lane), .ctrl_addr(ctrl_addr),
        .window_rd(window_rd), .window_wr(window_wr), .window_wr_lane(window_wr_lane),
        .window_addr(window_addr), .window_rd_data(window_rd_data),
        .fault_pulse(fault_pulse), .fault_on_write(fault_on_write),
        .reg_in(reg_in), .byte_in(byte_in), .ext_op(ext_op), .reg_out(reg_out));

    dsacc_core_model u_dsacc_core_model (.ctrl_addr(ctrl_addr),
        .window_addr(window_addr), .ctrl_rd_data(ctrl_rd_data),
        .ctrl_rd_hit(ctrl_rd_hit), .window_rd_data(window_rd_data));

    // Clock generator
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Verdict and end of run
    task automatic report_and_stop;
        if (n_mismatch == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    // Raise one post-incremented request; comb outputs settle for checking
    task automatic req(input logic wr, input logic by, input logic [15:0] a,
                       input logic [15:0] d);
        @(negedge ref_clk);
        if (wr) begin
            wr_req  <= '{1'b1, by, 1'b1, a};
            wr_data <= d;
        end else begin
            rd_req  <= '{1'b1, by, 1'b1, a};
        end
        #10;
    endtask : req

    // Drop requests; registered answers are then standing
    task automatic fin;
        @(negedge ref_clk);
        rd_req.valid <= 1'b0;
        wr_req.valid <= 1'b0;
        #1;
    endtask : fin

    // Word and byte lanes in RAM
    task automatic t_ram;
        req(1'b1, 1'b0, 16'h0800, 16'hA55A);
        chk(wr_pointer_next, 16'h0802);
        chk({ctrl_wr_en, window_wr}, 16'h0000);
        fin;
        req(1'b1, 1'b1, 16'h0801, 16'h0033);
        chk(wr_pointer_next, 16'h0802);
        fin;
        req(1'b0, 1'b0, 16'h0800, 16'h0000);
        chk(window_rd, 16'h0000);
        fin;
        chk(rd_valid, 16'h0001);
        chk(rd_data, 16'h335A);
        req(1'b0, 1'b1, 16'h0801, 16'h0000);
        chk(rd_pointer_next, 16'h0802);
        fin;
        chk(rd_data, 16'h0033);
        req(1'b0, 1'b1, 16'h0800, 16'h0000);
        fin;
        chk(rd_data, 16'h005A);
        @(negedge ref_clk);
        rd_req <= '{1'b0, 1'b0, 1'b0, 16'h0900};
        #10 chk(rd_pointer_next, 16'h0900);
    endtask : t_ram

    // Odd word accesses trap; write suppressed, read completes
    task automatic t_fault;
        req(1'b1, 1'b0, 16'h0802, 16'h1111);
        fin;
        req(1'b1, 1'b0, 16'h0803, 16'hBEEF);
        fin;
        chk({fault_pulse, fault_on_write}, 16'h0003);
        @(negedge ref_clk);
        chk(fault_pulse, 16'h0000);
        req(1'b0, 1'b0, 16'h0802, 16'h0000);
        fin;
        chk(rd_data, 16'h1111);
        req(1'b0, 1'b0, 16'h0805, 16'h0000);
        fin;
        chk({fault_pulse, fault_on_write, rd_valid}, 16'h0005);
    endtask : t_fault

    // Upper half goes to the window
    task automatic t_window;
        req(1'b0, 1'b0, 16'h8000, 16'h0000);
        chk(window_rd, 16'h0001);
        chk(window_addr, 16'h8000);
        fin;
        chk(rd_data, 16'h7FFF);
        req(1'b1, 1'b1, 16'hFFFF, 16'h00AB);
        chk({window_wr, window_wr_lane}, 16'h0006);
        fin;
    endtask : t_window

    // Control region writes, reads and unimplemented zeros
    task automatic t_ctrl;
        req(1'b1, 1'b0, 16'h07FE, 16'h1234);
        chk(ctrl_wr_en, 16'h0001);
        chk(ctrl_wr_lane, 16'h0003);
        chk(ctrl_addr, 16'h07FE);
        fin;
        req(1'b1, 1'b1, 16'h0100, 16'h0056);
        chk({ctrl_wr_en, ctrl_wr_lane}, 16'h0005);
        fin;
        req(1'b1, 1'b0, 16'h7FFE, 16'h0000);
        chk(ctrl_wr_en, 16'h0000);
        fin;
        req(1'b0, 1'b0, 16'h0040, 16'h0000);
        fin;
        chk(rd_data, 16'hC340);
        req(1'b0, 1'b0, 16'h0600, 16'h0000);
        fin;
        chk(rd_data, 16'h0000);
    endtask : t_ctrl

    // Register-side byte load and extensions
    task automatic t_ext;
        @(negedge ref_clk);
        reg_in  = 16'h3412;
        byte_in = 8'h9A;
        ext_op  = DSACC_EXT_BYTE_LOAD;
        #10 chk(reg_out, 16'h349A);
        @(negedge ref_clk);
        reg_in  = 16'h34F0;
        byte_in = 8'hF0;
        ext_op  = DSACC_EXT_SIGN;
        #10 chk(reg_out, 16'hFFF0);
        @(negedge ref_clk);
        ext_op  = DSACC_EXT_CLEAR;
        #10 chk(reg_out, 16'h00F0);
        @(negedge ref_clk);
        ext_op  = DSACC_EXT_NONE;
        #10 chk(reg_out, 16'h34F0);
    endtask : t_ext

    // Hang guard
    initial begin
        #200000;
        n_mismatch++;
        report_and_stop;
    end

    // Main sequence
    initial begin
        n_mismatch = 0;
        checked    = 0;
        nrst       = 1'b0;
        rd_req     = '0;
        wr_req     = '0;
        wr_data    = 16'h0000;
        reg_in     = 16'h0000;
        byte_in    = 8'h00;
        ext_op     = DSACC_EXT_NONE;
        repeat (5) @(negedge ref_clk);
        nrst = 1'b1;
        t_ram;
        t_fault;
        t_window;
        t_ctrl;
        t_ext;
        report_and_stop;
    end
endmodule : dsacc_top_tb_top
